// >>> pkg/dppio_defs.svh
// Purpose: constants for the dual port pin i/o block
// Assumes: 250 MHz ref_clk
// Notes: times in ns, counts derived from them
`ifndef DPPIO_DEFS_SVH
`define DPPIO_DEFS_SVH
`define DPPIO_WIDE_W 8
`define DPPIO_NARROW_W 4
`define DPPIO_CLK_NS 4
`define DPPIO_RST_MIN_NS 2000
`define DPPIO_RST_MIN_CYC \
  ((`DPPIO_RST_MIN_NS + `DPPIO_CLK_NS - 1) / `DPPIO_CLK_NS)
`define DPPIO_CNT_W 16
`endif

// >>> pkg/dppio_pkg.sv
// Purpose: types for the dual port pin i/o block
// Assumes: nothing
// Notes: reset pin filter states
package dppio_pkg;
  typedef enum logic [1:0] {
    DPPIO_IDLE = 2'b00,
    DPPIO_COUNT = 2'b01,
    DPPIO_HOLD = 2'b10
  } dppio_rst_e;
endpackage

// >>> core/dppio_top.sv
// Purpose: pin-level logic of an 8-bit and a 4-bit general i/o port
// Assumes: pin levels arrive asynchronously; control from core logic
// Notes: the top narrow pin is the reset input unless the fuse is 0
`timescale 1ns/1ns
`include "dppio_defs.svh"

// How it works
// - the narrow port has four two-way pins, each with its own pull-up.
// - the top narrow pin is the reset input unless the fuse reads zero.
// - every narrow pin stops driving while any reset is active.
// - a reset-pin low longer than the least pulse raises the chip reset.
// - the wide port has eight two-way pins, each with its own pull-up.
// - every wide pin stops driving while any reset is active.
// - wide pins may be handed to alternate functions.
// - narrow pins may be handed to alternate functions.
module dppio_top #(
  parameter int WIDE_W = `DPPIO_WIDE_W,
  parameter int NARROW_W = `DPPIO_NARROW_W,
  parameter int RST_MIN_CYC = `DPPIO_RST_MIN_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // strap
  input wire logic reset_pin_disable_fuse,
  // wide port control from core
  input wire logic [WIDE_W-1:0] wide_dir,
  input wire logic [WIDE_W-1:0] wide_out,
  input wire logic [WIDE_W-1:0] wide_pull,
  input wire logic [WIDE_W-1:0] wide_alt_en,
  input wire logic [WIDE_W-1:0] wide_alt_oe,
  input wire logic [WIDE_W-1:0] wide_alt_out,
  // narrow port control from core
  input wire logic [NARROW_W-1:0] narrow_dir,
  input wire logic [NARROW_W-1:0] narrow_out,
  input wire logic [NARROW_W-1:0] narrow_pull,
  input wire logic [NARROW_W-1:0] narrow_alt_en,
  input wire logic [NARROW_W-1:0] narrow_alt_oe,
  input wire logic [NARROW_W-1:0] narrow_alt_out,
  // wide pins
  input wire logic [WIDE_W-1:0] wide_port_pins_in,
  output logic [WIDE_W-1:0] wide_port_pins_out,
  output logic [WIDE_W-1:0] wide_port_pins_oe,
  output logic [WIDE_W-1:0] wide_port_pins_pu,
  // narrow pins
  input wire logic [NARROW_W-1:0] narrow_port_pins_in,
  output logic [NARROW_W-1:0] narrow_port_pins_out,
  output logic [NARROW_W-1:0] narrow_port_pins_oe,
  output logic [NARROW_W-1:0] narrow_port_pins_pu,
  // readback and reset to core
  output logic [WIDE_W-1:0] wide_in_data,
  output logic [NARROW_W-1:0] narrow_in_data,
  output logic chip_reset
);
  import dppio_pkg::*;

  localparam int ALL_W = WIDE_W + NARROW_W;
  localparam int TOP = ALL_W - 1;
  // sync reset value: the reset pin idles high, every other pin reads low
  localparam logic [ALL_W-1:0] SYNC_RST = {1'b1, {TOP{1'b0}}};

  logic [ALL_W-1:0] sync1;
  logic [ALL_W-1:0] sync2;
  logic fuse_s1;
  logic fuse_s2;
  logic [ALL_W-1:0] dir_all;
  logic [ALL_W-1:0] out_all;
  logic [ALL_W-1:0] pull_all;
  logic [ALL_W-1:0] aen_all;
  logic [ALL_W-1:0] aoe_all;
  logic [ALL_W-1:0] aout_all;
  logic [ALL_W-1:0] pin_out;
  logic [ALL_W-1:0] pin_oe;
  logic [ALL_W-1:0] pin_pu;
  logic [ALL_W-1:0] next_pin_out;
  logic [ALL_W-1:0] next_pin_oe;
  logic [ALL_W-1:0] next_pin_pu;
  dppio_rst_e state;
  dppio_rst_e next_state;
  logic [`DPPIO_CNT_W-1:0] cnt;
  logic [`DPPIO_CNT_W-1:0] next_cnt;
  logic next_chip_reset;
  logic rst_pin_low;
  logic reset_active;

  // gather both ports into one vector, narrow on top
  assign dir_all = {narrow_dir, wide_dir};
  assign out_all = {narrow_out, wide_out};
  assign pull_all = {narrow_pull, wide_pull};
  assign aen_all = {narrow_alt_en, wide_alt_en};
  assign aoe_all = {narrow_alt_oe, wide_alt_oe};
  assign aout_all = {narrow_alt_out, wide_alt_out};

  // two-flop synchronisers for pins and the fuse strap
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      // a cleared reset-pin sync would fake a low pulse after every reset
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
      fuse_s1 <= 1'b1;
      fuse_s2 <= 1'b1;
    end else begin
      sync1 <= {narrow_port_pins_in, wide_port_pins_in};
      sync2 <= sync1;
      fuse_s1 <= reset_pin_disable_fuse;
      fuse_s2 <= fuse_s1;
    end
  end

  // the reset function exists only while the fuse is unprogrammed
  assign rst_pin_low = fuse_s2 & ~sync2[TOP];
  assign reset_active = sys_rst | chip_reset;

  // reset pin low filter; short pulses fall back to idle
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    unique case (state)
      DPPIO_IDLE: begin
        next_cnt = '0;
        if (rst_pin_low) begin
          next_state = DPPIO_COUNT;
          next_cnt = `DPPIO_CNT_W'(1);
        end
      end
      DPPIO_COUNT: begin
        if (!rst_pin_low) begin
          next_state = DPPIO_IDLE;
        end else if (cnt >= `DPPIO_CNT_W'(RST_MIN_CYC)) begin
          next_state = DPPIO_HOLD;
        end else begin
          next_cnt = cnt + `DPPIO_CNT_W'(1);
        end
      end
      DPPIO_HOLD: begin
        if (!rst_pin_low) begin
          next_state = DPPIO_IDLE;
        end
      end
      default: begin
        next_state = DPPIO_IDLE;
      end
    endcase
    next_chip_reset = (next_state == DPPIO_HOLD);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= DPPIO_IDLE;
      cnt <= '0;
      chip_reset <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      chip_reset <= next_chip_reset;
    end
  end

  // per-bit pad control: alternate function wins over plain i/o
  for (genvar i = 0; i < ALL_W; i++) begin : g_bit
    always_comb begin
      next_pin_out[i] = aen_all[i] ? aout_all[i] : out_all[i];
      next_pin_oe[i] = ~reset_active
        & (aen_all[i] ? aoe_all[i] : dir_all[i]);
      next_pin_pu[i] = ~reset_active & pull_all[i]
        & ~(aen_all[i] ? aoe_all[i] : dir_all[i]);
      if (i == TOP && fuse_s2) begin
        // reset pin: never driven, pull-up on except during sys_rst so it idles high
        next_pin_out[i] = 1'b0;
        next_pin_oe[i] = 1'b0;
        next_pin_pu[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_out <= '0;
      pin_oe <= '0;
      pin_pu <= '0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      pin_pu <= next_pin_pu;
    end
  end

  // split back to the two ports; all straight from flops
  assign wide_port_pins_out = pin_out[WIDE_W-1:0];
  assign wide_port_pins_oe = pin_oe[WIDE_W-1:0];
  assign wide_port_pins_pu = pin_pu[WIDE_W-1:0];
  assign narrow_port_pins_out = pin_out[TOP:WIDE_W];
  assign narrow_port_pins_oe = pin_oe[TOP:WIDE_W];
  assign narrow_port_pins_pu = pin_pu[TOP:WIDE_W];
  assign wide_in_data = sync2[WIDE_W-1:0];
  assign narrow_in_data = sync2[TOP:WIDE_W];

  // helper: run length of the synchronised reset-pin low level
  logic [`DPPIO_CNT_W-1:0] low_run;
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !rst_pin_low) begin
      low_run <= '0;
    end else if (low_run != '1) begin
      low_run <= low_run + `DPPIO_CNT_W'(1);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_sysrst_tristate: assert property (disable iff (1'b0)
    sys_rst |=> (pin_oe == '0 && pin_pu == '0))
    else $error("pins driven after system reset");
  a_chiprst_tristate: assert property (chip_reset |=> pin_oe == '0)
    else $error("pins driven during chip reset");
  a_pull_input_only: assert property ((pin_oe & pin_pu) == '0)
    else $error("pull-up on while driving");
  a_dir_drives_wide: assert property (
    (!reset_active && !wide_alt_en[0] && wide_dir[0])
    |=> (wide_port_pins_oe[0] && wide_port_pins_out[0] == $past(wide_out[0])))
    else $error("wide bit 0 not driven as output");
  a_alt_narrow: assert property (
    (!reset_active && narrow_alt_en[0])
    |=> narrow_port_pins_oe[0] == $past(narrow_alt_oe[0]))
    else $error("narrow alternate enable not followed");
  a_rstpin_undriven: assert property (fuse_s2 |=> !pin_oe[TOP])
    else $error("reset pin driven while reset enabled");
  a_rst_long_enough: assert property (
    $rose(chip_reset) |-> low_run > `DPPIO_CNT_W'(RST_MIN_CYC))
    else $error("chip reset raised on a short pulse");
  a_rst_release: assert property (
    (chip_reset && !rst_pin_low) |=> !chip_reset)
    else $error("chip reset held after pin release");
  a_fuse_blocks: assert property (!fuse_s2 |=> !chip_reset)
    else $error("chip reset with reset pin disabled");
  a_wide_alt_out: assert property (
    (!reset_active && wide_alt_en[1] && wide_alt_oe[1])
    |=> wide_port_pins_out[1] == $past(wide_alt_out[1]))
    else $error("wide alternate value not followed");

  c_chip_reset: cover property ($rose(chip_reset));
  c_short_pulse: cover property (state == DPPIO_COUNT && !rst_pin_low);
  c_top_gpio: cover property (!fuse_s2 && pin_oe[TOP]);
  c_wide_pullup: cover property (wide_port_pins_pu[0]);
endmodule

// >>> sim/dppio_board.sv
// Purpose: board circuitry seen on one port's pins
// Assumes: the bench picks which lines the board drives
// Notes: floating lines toggle each clock so stale levels never match
`timescale 1ns/1ns
module dppio_board #(
  parameter int W = 8
) (
  // clock
  input wire logic clk,
  // pad side of the block
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] pu,
  // board drivers
  input wire logic [W-1:0] drv_en,
  input wire logic [W-1:0] drv_val,
  output logic [W-1:0] pins
);
  logic [W-1:0] flip = '0;
  // undriven, unpulled lines wander every cycle
  always @(posedge clk) flip <= ~flip;
  // wire level from every party's enable, pad driver first
  assign pins = (oe & out) | (~oe & drv_en & drv_val)
    | (~oe & ~drv_en & (pu | flip));
endmodule

// >>> sim/tb.sv
// Purpose: self-checking bench for the dual port pin block
// Assumes: reset pin minimum shortened to 8 cycles
// Notes: pads and readback compared with a bench model
`timescale 1ns/1ns
module tb;
  localparam int RMC = 8;
  logic ref_clk = 0, sys_rst = 1, fuse = 1;
  logic [7:0] wd, wo, wp, wae, wao, wau, wpi, wpo, woe, wpu, wid, wde, wdv;
  logic [3:0] nd, no, np, nae, nao, nau, npi, npo, noe, npu, nid, nde, ndv;
  logic crst;
  int fail_count = 0, checks = 0, seed, xoe, xo, xpu, n;

  dppio_top #(.RST_MIN_CYC(RMC)) i_dppio_top (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .reset_pin_disable_fuse(fuse), .wide_dir(wd),
    .wide_out(wo), .wide_pull(wp), .wide_alt_en(wae), .wide_alt_oe(wao),
    .wide_alt_out(wau), .narrow_dir(nd), .narrow_out(no),
    .narrow_pull(np), .narrow_alt_en(nae), .narrow_alt_oe(nao),
    .narrow_alt_out(nau), .wide_port_pins_in(wpi),
    .wide_port_pins_out(wpo), .wide_port_pins_oe(woe),
    .wide_port_pins_pu(wpu), .narrow_port_pins_in(npi),
    .narrow_port_pins_out(npo), .narrow_port_pins_oe(noe),
    .narrow_port_pins_pu(npu), .wide_in_data(wid), .narrow_in_data(nid),
    .chip_reset(crst));
  dppio_board #(.W(8)) i_wide_board (.clk(ref_clk), .oe(woe), .out(wpo),
    .pu(wpu), .drv_en(wde), .drv_val(wdv), .pins(wpi));
  dppio_board #(.W(4)) i_narrow_board (.clk(ref_clk), .oe(noe),
    .out(npo), .pu(npu), .drv_en(nde), .drv_val(ndv), .pins(npi));

  // free-running clock
  initial forever #2 ref_clk = ~ref_clk;

  task automatic end_sim();
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // expected pad state; top narrow bit is the reset pin when fused on
  task automatic model(input int d, v, p, ae, ao, au, top);
    xoe = (ae & ao) | (~ae & d);
    xo = (ae & au) | (~ae & v);
    xpu = p & ~xoe;
    if (top != 0) begin
      xoe = xoe & 7;
      xpu = xpu | 8;
    end
  endtask

  task automatic port(input logic [7:0] oe, o, pu, id, dv,
                      input int d, v, p, ae, ao, au, top);
    model(d, v, p, ae, ao, au, top);
    chk(oe, 8'(xoe));
    chk(o & oe, 8'(xo & xoe));
    chk(pu, 8'(xpu));
    chk(id, 8'((xoe & xo) | (~xoe & dv)));
  endtask

  // random control; board drives only lines the pads leave free
  task automatic rnd();
    {wd, wo, wp, wae} = $urandom;
    {wao, wau, wdv} = 24'($urandom);
    {nd, no, np, nae, nao, nau} = 24'($urandom);
    // reset pin held high by the board while it acts as reset
    ndv = 4'($urandom) | {fuse, 3'h0};
    model(wd, wo, wp, wae, wao, wau, 0);
    wde = ~8'(xoe);
    model(nd, no, np, nae, nao, nau, fuse);
    nde = ~4'(xoe);
    tick(3);
    port(woe, wpo, wpu, wid, wdv, wd, wo, wp, wae, wao, wau, 0);
    port(noe, npo, npu, nid, ndv, nd, no, np, nae, nao, nau, fuse);
    chk({7'h0, crst}, 8'h00);
  endtask

  // hang guard
  initial begin
    #20000;
    fail_count++;
    end_sim();
  end

  // main sequence
  initial begin
    {wo, wp, wae, wao, wau, wde, wdv, no, np, nae, nao, nau} = '0;
    {wd, nd, nde, ndv} = {8'hFF, 4'hF, 4'hF, 4'hF};
    seed = $urandom(32'h6de9);
    tick(2);
    chk(woe, 8'h00);
    chk({4'h0, noe}, 8'h00);
    sys_rst = 0;
    for (n = 0; n < 40; n++) begin
      if (n == 20) begin
        fuse = 0;
        tick(3);
      end
      rnd();
    end
    fuse = 1;
    {wd, wae, wde, nd, nae, nde, ndv} = {8'hFF, 16'h0, 4'h0, 8'h0F, 4'hF};
    tick(4);
    // a two-cycle low is below the minimum and must not reset
    ndv = 4'h7;
    tick(2);
    ndv = 4'hF;
    tick(6);
    chk({7'h0, crst}, 8'h00);
    ndv = 4'h7;
    n = 0;
    while (crst !== 1'b1 && n < RMC + 10) begin
      tick(1);
      n++;
    end
    chk(8'(n >= RMC && n <= RMC + 4), 8'h01);
    tick(1);
    chk(woe, 8'h00);
    chk({4'h0, noe}, 8'h00);
    ndv = 4'hF;
    tick(6);
    chk({7'h0, crst}, 8'h00);
    chk(woe, 8'hFF);
    // a system reset in mid-run frees the pins, then hands them back
    sys_rst = 1;
    nd = 4'h7;
    tick(1);
    chk(woe, 8'h00);
    chk({4'h0, noe}, 8'h00);
    sys_rst = 0;
    tick(2);
    chk(woe, 8'hFF);
    chk({4'h0, noe}, 8'h07);
    chk({7'h0, crst}, 8'h00);
    end_sim();
  end
endmodule
